// ### hdl/assm_top.sv
// Master-mode transmit path of the audio serial port used as a synchronous serial master.
// Assumes bytes arrive from a same-clock RAM reader and suspend pins are asynchronous.
// What this block does
// - master needs system clock source and master enable
// - bit clock is sysclk over 2, 4 or 8 with divider setting 00
// - word length 00 is 16 bits, 11 is 24
// - divider setting 00 passes master clock undivided
// - format check enable turns LR checking on
// - selected port pin pauses transmission when enabled
// - polarity bit 0 requests high, 1 requests low
// - swap bit exchanges high and low word bytes
// - works whether or not LR clock is driven
// - auto-stop clears run flag at transfer end
// - last byte fetched: set end, clear run with auto-stop, interrupt if enabled
// - serial data finishes within three channel halves of the last byte
// - end interrupt enable gates end flag to interrupt
// - clock enable starts LR and bit clock generation
// - direction 0 moves RAM bytes to transmit buffer
`timescale 1ns/1ps
`default_nettype none
module assm_top
  import assm_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Register bus
  input wire assm_pkg::assm_axil_req_s i_axil,
  output var assm_pkg::assm_axil_rsp_s o_axil,
  // Byte source from RAM
  input wire logic [7:0] i_byte_data,
  input wire logic i_byte_valid,
  output logic o_byte_ready,
  // Suspend request pins, asynchronous
  input wire logic [3:0] i_suspend_pins,
  // Serial pins and interrupt
  output var assm_pkg::assm_pins_s o_pins,
  output logic o_irq
);
  import assm_pkg::*;

  // Software registers
  logic [7:0] fmt_par_r, suspend_r, rate_r, wmode_r, clk_r, pindir_r, xctrl_r;
  logic [CNT_W-1:0] count_r;  // programmed byte count
  logic fmt_err_r;  // sticky LR format error
  assm_axil_rsp_s rsp_r;  // registered bus answer
  // Datapath state
  logic [3:0] pin_s1_r, pin_s2_r;  // two-flop suspend pin synchroniser, only stage two is read
  logic [4:0] div_cnt_r;  // bit clock half-period counter
  logic bclk_r, lr_clock_r, sdat_r, pause_r;
  logic [5:0] slot_r;  // bit slot within channel half
  logic [23:0] asm_r, buf_r, word_r;  // assembly, transmit buffer, shifting word
  logic [1:0] asm_n_r;  // bytes held in assembly
  logic buf_full_r, wvalid_r, wpar_r;
  logic rdy_r, irq_r;
  logic [CNT_W-1:0] byte_cnt_r;
  logic [1:0] halves_r;  // channel halves since end flag rose
  assm_pins_s pins_r;

  // Decoded controls
  logic master_on, fetch_ok, take, last_byte, tick, wrap, req_pin, susp_block;
  logic is24, par_on, wr_en, rd_en, start_pulse;
  logic [1:0] bpw, rsh;
  logic [2:0] shamt;
  logic [4:0] lim;
  logic [5:0] wlen, half, nb, start, nslot, idx;
  logic [23:0] wsrc;
  logic wok, nbit;

  // Mode and clock decode; inputs of other modes are never read
  always_comb
  begin
    master_on = suspend_r[F_MSTEN] & suspend_r[F_MASTER_CLK_SOURCE_SEL] & xctrl_r[F_CLKON];
    fetch_ok = master_on & xctrl_r[F_RUN] & ~xctrl_r[F_DIR];
    is24 = (wmode_r[F_WLEN +: 2] == WLEN_24);
    bpw = is24 ? 2'h3 : 2'h2;
    wlen = is24 ? BITS_24 : BITS_16;
    // Parity is only meaningful on 16-bit words
    par_on = fmt_par_r[F_PARITY_CHECK_EN] & ~is24;
    nb = wlen + {5'h00, par_on};
    half = clk_r[F_BIT_CLK_RATIO_SEL] ? HALF_64FS : HALF_48FS;
    start = wmode_r[F_JUST] ? (half - nb) : 6'h00;
    rsh = rate_r[F_RATE + 1] ? 2'h2 : {1'b0, rate_r[F_RATE]};
    shamt = {1'b0, rsh} + {1'b0, fmt_par_r[F_MASTER_CLK_DIVIDER +: 2]};
    lim = 5'((6'h01 << shamt) - 6'h01);
    tick = master_on & ~pause_r & (div_cnt_r == lim);
    wrap = tick & bclk_r & (slot_r == half - 6'h01);
    nslot = wrap ? 6'h00 : slot_r + 6'h01;
    wsrc = wrap ? buf_r : word_r;
    wok = wrap ? buf_full_r : wvalid_r;
    idx = nslot - start;
    take = rdy_r & i_byte_valid;
    last_byte = take & (byte_cnt_r + 13'h0001 == count_r);
    req_pin = pin_s2_r[suspend_r[F_SUSSEL +: 2]] ^ suspend_r[F_SUSPOL];
    susp_block = suspend_r[F_PINSUS] & ~req_pin;
  end

  // Serial bit of the current word for a slot index
  function automatic logic bit_of(input logic [23:0] w, input logic [5:0] i, input logic [5:0] wl,
                                  input logic msb);
    logic [5:0] k;
    k = msb ? (wl - 6'h01 - i) : i;
    return (i == wl) ? ^w[15:0] : w[k[4:0]];
  endfunction : bit_of

  always_comb
  begin
    nbit = 1'b0;
    if (wok && nslot >= start && idx < nb)
    begin
      nbit = bit_of(wsrc, idx, wlen, xctrl_r[F_MSBF]);
    end
  end

  // Bus handshake: write needs address and data both present
  assign wr_en = rsp_r.awready & i_axil.awvalid & i_axil.wvalid;
  assign rd_en = rsp_r.arready & i_axil.arvalid;
  assign start_pulse = wr_en & (i_axil.awaddr == OFS_XFER_CTRL) & i_axil.wstrb[0]
                       & i_axil.wdata[F_RUN] & ~xctrl_r[F_RUN];

  // AXI4-Lite ready, response and read data
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      rsp_r <= '0;
    end
    else if (i_ce)
    begin
      rsp_r.awready <= ~rsp_r.awready & ~rsp_r.bvalid & i_axil.awvalid & i_axil.wvalid;
      rsp_r.wready <= ~rsp_r.awready & ~rsp_r.bvalid & i_axil.awvalid & i_axil.wvalid;
      rsp_r.arready <= ~rsp_r.arready & ~rsp_r.rvalid & i_axil.arvalid;
      if (wr_en)
      begin
        rsp_r.bvalid <= 1'b1;
        rsp_r.bresp <= (i_axil.awaddr > OFS_STATUS || i_axil.awaddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (i_axil.bready)
      begin
        rsp_r.bvalid <= 1'b0;
      end
      if (rd_en)
      begin
        rsp_r.rvalid <= 1'b1;
        rsp_r.rresp <= RESP_OKAY;
        unique case (i_axil.araddr)
          OFS_FMT_PAR: rsp_r.rdata <= {24'h000000, fmt_par_r};
          OFS_SUSPEND: rsp_r.rdata <= {24'h000000, suspend_r};
          OFS_RATE: rsp_r.rdata <= {24'h000000, rate_r};
          OFS_WORD_MODE: rsp_r.rdata <= {24'h000000, wmode_r};
          OFS_CLK: rsp_r.rdata <= {24'h000000, clk_r};
          OFS_PIN_DIR: rsp_r.rdata <= {24'h000000, pindir_r};
          OFS_XFER_CTRL: rsp_r.rdata <= {24'h000000, xctrl_r};
          OFS_XFER_COUNT: rsp_r.rdata <= {19'h00000, count_r};
          OFS_STATUS: rsp_r.rdata <= {30'h00000000, buf_full_r | wvalid_r, fmt_err_r};
          default:
          begin
            // Unmapped addresses read zero with an error
            rsp_r.rdata <= 32'h00000000;
            rsp_r.rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (i_axil.rready)
      begin
        rsp_r.rvalid <= 1'b0;
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      fmt_par_r <= REG_RST;
      suspend_r <= REG_RST;
      rate_r <= REG_RST;
      wmode_r <= REG_RST;
      clk_r <= REG_RST;
      pindir_r <= REG_RST;
      count_r <= '0;
    end
    else if (i_ce && wr_en)
    begin
      if (i_axil.wstrb[0])
      begin
        unique case (i_axil.awaddr)
          OFS_FMT_PAR: fmt_par_r <= i_axil.wdata[7:0];
          OFS_SUSPEND: suspend_r <= i_axil.wdata[7:0];
          OFS_RATE: rate_r <= i_axil.wdata[7:0];
          OFS_WORD_MODE: wmode_r <= i_axil.wdata[7:0];
          OFS_CLK: clk_r <= i_axil.wdata[7:0];
          OFS_PIN_DIR: pindir_r <= i_axil.wdata[7:0];
          OFS_XFER_COUNT: count_r[7:0] <= i_axil.wdata[7:0];
          default:
          begin
            // Other offsets have their own owners
          end
        endcase
      end
      if (i_axil.wstrb[1] && i_axil.awaddr == OFS_XFER_COUNT)
      begin
        count_r[CNT_W-1:8] <= i_axil.wdata[CNT_W-1:8];
      end
    end
  end

  // Transfer control: end flag is set by hardware and written 0 to clear; set wins
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      xctrl_r <= REG_RST;
    end
    else if (i_ce)
    begin
      if (wr_en && i_axil.wstrb[0] && i_axil.awaddr == OFS_XFER_CTRL)
      begin
        xctrl_r <= {i_axil.wdata[7:2], xctrl_r[F_ENDF] & i_axil.wdata[F_ENDF], i_axil.wdata[F_ENDIE]};
      end
      if (last_byte)
      begin
        xctrl_r[F_ENDF] <= 1'b1;
        if (xctrl_r[F_AUTOSTOP] && !start_pulse)
        begin
          xctrl_r[F_RUN] <= 1'b0;
        end
      end
    end
  end

  // Status: format error when a transfer ends on an unpaired channel word; write 1 clears
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      fmt_err_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (last_byte && fmt_par_r[F_LR_FORMAT_CHECK_EN] && !wpar_r)
      begin
        fmt_err_r <= 1'b1;
      end
      else if (wr_en && i_axil.awaddr == OFS_STATUS && i_axil.wstrb[0] && i_axil.wdata[F_FMTERR])
      begin
        fmt_err_r <= 1'b0;
      end
    end
  end

  // Suspend pins cross into the clock domain through two flops
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end
    else if (i_ce)
    begin
      pin_s1_r <= i_suspend_pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Byte fetch from RAM; ready drops for a cycle after each byte so counts settle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      rdy_r <= 1'b0;
      byte_cnt_r <= '0;
      asm_r <= 24'h000000;
      asm_n_r <= 2'h0;
      wpar_r <= 1'b0;
    end
    else if (i_ce)
    begin
      rdy_r <= fetch_ok & ~take & ~last_byte & (asm_n_r < bpw) & (byte_cnt_r < count_r);
      if (start_pulse || !master_on)
      begin
        // Clock enable low reinitialises the datapath
        byte_cnt_r <= '0;
        asm_n_r <= 2'h0;
        wpar_r <= 1'b0;
      end
      else if (take)
      begin
        byte_cnt_r <= byte_cnt_r + 13'h0001;
        asm_r[8 * asm_n_r +: 8] <= i_byte_data;
        asm_n_r <= asm_n_r + 2'h1;
      end
      else if (asm_n_r == bpw && !buf_full_r)
      begin
        asm_n_r <= 2'h0;
        wpar_r <= ~wpar_r;
      end
    end
  end

  // Transmit buffer: filled from assembly, emptied at each channel boundary
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      buf_r <= 24'h000000;
      buf_full_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (!master_on)
      begin
        buf_full_r <= 1'b0;
      end
      else if (wrap)
      begin
        buf_full_r <= 1'b0;
      end
      else if (!take && asm_n_r == bpw && !buf_full_r)
      begin
        buf_full_r <= 1'b1;
        if (rate_r[F_SWAP])
        begin
          buf_r <= is24 ? {asm_r[7:0], asm_r[15:8], asm_r[23:16]} : {8'h00, asm_r[7:0], asm_r[15:8]};
        end
        else
        begin
          buf_r <= is24 ? asm_r : {8'h00, asm_r[15:0]};
        end
      end
    end
  end

  // Bit clock divider, slot counter, LR clock and serial data
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      div_cnt_r <= 5'h00;
      bclk_r <= 1'b0;
      lr_clock_r <= 1'b0;
      sdat_r <= 1'b0;
      slot_r <= 6'h00;
      word_r <= 24'h000000;
      wvalid_r <= 1'b0;
      pause_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (!master_on)
      begin
        // Idle with clocks low until generation is enabled
        div_cnt_r <= 5'h00;
        bclk_r <= 1'b0;
        lr_clock_r <= 1'b0;
        sdat_r <= 1'b0;
        slot_r <= 6'h00;
        wvalid_r <= 1'b0;
        pause_r <= 1'b0;
      end
      else if (pause_r)
      begin
        // Resume once the far end requests data again
        pause_r <= susp_block;
      end
      else if (tick)
      begin
        div_cnt_r <= 5'h00;
        bclk_r <= ~bclk_r;
        if (bclk_r)
        begin
          // Data changes on the falling edge, read on the rising edge
          slot_r <= nslot;
          sdat_r <= nbit;
          if (wrap)
          begin
            lr_clock_r <= ~lr_clock_r;
            word_r <= buf_r;
            wvalid_r <= buf_full_r;
            pause_r <= susp_block;
          end
        end
      end
      else
      begin
        div_cnt_r <= div_cnt_r + 5'h01;
      end
    end
  end

  // Pins and interrupt straight from flops; the LR pin is optional
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      pins_r <= '0;
      irq_r <= 1'b0;
    end
    else if (i_ce)
    begin
      pins_r.bclk <= bclk_r;
      pins_r.sdat <= sdat_r;
      pins_r.lr_clock <= lr_clock_r;
      pins_r.bclk_oe <= suspend_r[F_MSTEN] & pindir_r[F_BIT_CLK_OUT_EN];
      pins_r.sdat_oe <= suspend_r[F_MSTEN] & pindir_r[F_SER_DATA_OUT_EN];
      pins_r.lr_clock_oe <= suspend_r[F_MSTEN] & pindir_r[F_LRDR];
      irq_r <= xctrl_r[F_ENDF] & xctrl_r[F_ENDIE];
    end
  end

  // Channel halves since the end flag rose, for the drain bound
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      halves_r <= 2'h0;
    end
    else if (i_ce)
    begin
      if (last_byte)
      begin
        halves_r <= 2'h0;
      end
      else if (wrap && halves_r != 2'h3)
      begin
        halves_r <= halves_r + 2'h1;
      end
    end
  end

  assign o_axil = rsp_r;
  assign o_pins = pins_r;
  assign o_byte_ready = rdy_r;
  assign o_irq = irq_r;

  default clocking cb @(posedge i_ref_clk iff i_ce);
  endclocking
  default disable iff (i_srst);

  sequence s_fast_cfg;
    master_on && !pause_r && rate_r[F_RATE +: 2] == 2'h0 && fmt_par_r[F_MASTER_CLK_DIVIDER +: 2] == 2'h0;
  endsequence
  property p_div_pass;
    (s_fast_cfg and $rose(bclk_r)) ##1 s_fast_cfg |-> !bclk_r;
  endproperty
  a_div_pass: assert property (p_div_pass) else $error("undivided bit clock not half rate");
  property p_div_four;
    master_on && !pause_r && rate_r[F_RATE +: 2] == 2'h1 && fmt_par_r[F_MASTER_CLK_DIVIDER +: 2] == 2'h0 && $rose(bclk_r)
      ##1 !pause_r |-> bclk_r;
  endproperty
  a_div_four: assert property (p_div_four) else $error("quarter rate bit clock high too short");
  property p_end_set;
    last_byte |=> xctrl_r[F_ENDF];
  endproperty
  a_end_set: assert property (p_end_set) else $error("end flag not set on last byte");
  property p_auto_stop;
    last_byte && xctrl_r[F_AUTOSTOP] && !start_pulse |=> !xctrl_r[F_RUN] ##1 !o_byte_ready;
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("run flag not cleared at end");
  property p_irq;
    xctrl_r[F_ENDF] && xctrl_r[F_ENDIE] |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("end interrupt missing");
  property p_no_clk;
    // Three cycles: one to clear the internal clock, one more for the pin flop
    !master_on [*3] |-> !bclk_r && !o_pins.bclk;
  endproperty
  a_no_clk: assert property (p_no_clk) else $error("bit clock runs while disabled");
  property p_pause;
    pause_r |=> $stable(bclk_r) && $stable(slot_r);
  endproperty
  a_pause: assert property (p_pause) else $error("bit clock moves while suspended");
  property p_drain;
    (wvalid_r || buf_full_r) && xctrl_r[F_ENDF] |-> halves_r != 2'h3;
  endproperty
  a_drain: assert property (p_drain) else $error("data still shifting after drain bound");

endmodule : assm_top
`default_nettype wire

// ### hdl/assm_pkg.sv
// Constants, register map and carrier types of the audio serial master.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz system clock.
package assm_pkg;

  // Bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FMT_PAR = 6'h00;  // format_parity_check_ctrl
  localparam logic [ADDR_W-1:0] OFS_SUSPEND = 6'h04;  // master_suspend_ctrl
  localparam logic [ADDR_W-1:0] OFS_RATE = 6'h08;  // rate_swap_ctrl
  localparam logic [ADDR_W-1:0] OFS_WORD_MODE = 6'h0c;  // word_format_mode
  localparam logic [ADDR_W-1:0] OFS_CLK = 6'h10;  // audio_clock_ctrl
  localparam logic [ADDR_W-1:0] OFS_PIN_DIR = 6'h14;  // pin_direction_ctrl
  localparam logic [ADDR_W-1:0] OFS_XFER_CTRL = 6'h18;  // transfer_control
  localparam logic [ADDR_W-1:0] OFS_XFER_COUNT = 6'h1c;  // byte count
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h20;  // status

  // Field positions
  localparam int F_MASTER_CLK_DIVIDER = 5;  // master_clk_divider, 2 bits
  localparam int F_LR_FORMAT_CHECK_EN = 4;  // lr_format_check_en
  localparam int F_PARITY_CHECK_EN = 3;  // parity_check_en
  localparam int F_MASTER_CLK_SOURCE_SEL = 6;  // master_clk_source_sel
  localparam int F_MSTEN = 5;  // master_mode_en
  localparam int F_SOFTSUS = 4;  // soft_suspend_en
  localparam int F_PINSUS = 3;  // pin_suspend_en
  localparam int F_SUSPOL = 2;  // suspend_polarity
  localparam int F_SUSSEL = 0;  // suspend_pin_sel, 2 bits
  localparam int F_SWAP = 4;  // word_half_swap
  localparam int F_RATE = 0;  // bit_rate_select, 2 bits
  localparam int F_WLEN = 6;  // word_length_sel, 2 bits
  localparam int F_JUST = 5;  // justify_sel
  localparam int F_BIT_CLK_RATIO_SEL = 0;  // bit_clk_ratio_sel
  localparam int F_LRDR = 2;  // lr_clk_out_en
  localparam int F_BIT_CLK_OUT_EN = 1;  // bit_clk_out_en
  localparam int F_SER_DATA_OUT_EN = 0;  // ser_data_out_en
  localparam int F_CLKON = 6;  // clk_gen_en
  localparam int F_RUN = 5;  // run_flag
  localparam int F_AUTOSTOP = 4;  // auto_stop_en
  localparam int F_DIR = 3;  // xfer_direction
  localparam int F_MSBF = 2;  // bit_order_sel
  localparam int F_ENDF = 1;  // end_flag
  localparam int F_ENDIE = 0;  // end_irq_en
  localparam int F_FMTERR = 0;  // status: format error
  localparam int F_BUSY = 1;  // status: word in flight

  // Reset values and encodings
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_24 = 2'h3;
  localparam logic [5:0] BITS_16 = 6'h10;
  localparam logic [5:0] BITS_24 = 6'h18;
  localparam logic [5:0] HALF_48FS = 6'h18;  // bit slots per channel at 48 fs
  localparam logic [5:0] HALF_64FS = 6'h20;  // bit slots per channel at 64 fs
  localparam int CNT_W = 13;  // transfer count up to 8191
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // AXI4-Lite request from master
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } assm_axil_req_s;

  // AXI4-Lite answer to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } assm_axil_rsp_s;

  // Serial pins, each with its output enable
  typedef struct packed {
    logic bclk;
    logic bclk_oe;
    logic sdat;
    logic sdat_oe;
    logic lr_clock;
    logic lr_clock_oe;
  } assm_pins_s;

endpackage : assm_pkg

// ### sim/assm_rx_model.sv
// Far-side serial receiver clocked by the block's bit clock.
// Assumes the data pin changes on bit clock falls, so bits are taken on rises.
`timescale 1ns/1ps
`default_nettype none
module assm_rx_model (
  // Serial pins from the block
  input wire logic i_bclk,
  input wire logic i_lr_clock,
  input wire logic i_sdat,
  // Request pin control from the bench
  input wire logic i_hold,
  input wire logic [1:0] i_hold_sel,
  input wire logic i_pol,
  // Request pins towards the block
  output logic [3:0] o_req_pins
);
  logic [23:0] word_r;  // Slots of the current channel half, first bit at bit 0
  int cnt;  // Slot index within the half
  logic lr_last;  // Channel level seen last
  logic [23:0] words[$];  // Non-zero halves, read by the bench

  // Every pin requests data, except the held one, which shows the idle level
  assign o_req_pins = {4{~i_pol}} ^ (i_hold ? (4'h1 << i_hold_sel) : 4'h0);

  initial
  begin
    word_r = '0;
    cnt = 0;
    lr_last = 1'b0;
  end

  // Close a half on each channel change; empty halves carry no word
  always @(posedge i_bclk)
  begin
    if (i_lr_clock !== lr_last)
    begin
      if (word_r != 0) words.push_back(word_r);
      word_r = '0;
      cnt = 0;
      lr_last = i_lr_clock;
    end
    if (cnt < 24) word_r[cnt] = i_sdat;
    cnt++;
  end
endmodule : assm_rx_model
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench of the audio serial master over its register bus.
// Assumes one 100 MHz clock and the receiver model on the serial pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
  import assm_pkg::*;
  logic clk, srst, bval, brdy, irq, hold, pol;
  logic [7:0] bdat;
  logic [1:0] hsel, rr;
  logic [3:0] sus;
  logic [31:0] rd;
  assm_axil_req_s ax;
  assm_axil_rsp_s rs;
  assm_pins_s pins;
  logic [7:0] bq[$];  // Bytes still to hand to the block
  int fails, tests_run;

  assm_top i_dut (.i_ref_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_axil(ax), .o_axil(rs), .i_byte_data(bdat),
    .i_byte_valid(bval), .o_byte_ready(brdy), .i_suspend_pins(sus), .o_pins(pins), .o_irq(irq));
  assm_rx_model i_rx (.i_bclk(pins.bclk), .i_lr_clock(pins.lr_clock), .i_sdat(pins.sdat), .i_hold(hold),
    .i_hold_sel(hsel), .i_pol(pol), .o_req_pins(sus));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Byte source: next byte offered after each taken one
  always @(posedge clk)
  begin
    if (bval && brdy)
    begin
      void'(bq.pop_front());
      if (bq.size() > 0) bdat <= bq[0];
      else bval <= 1'b0;
    end
  end

  // Bus write; response code left in rr
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    ax.awaddr <= a;
    ax.awvalid <= 1'b1;
    ax.wdata <= d;
    ax.wstrb <= 4'hf;
    ax.wvalid <= 1'b1;
    ax.bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (rs.awready === 1'b1) ax.awvalid <= 1'b0;
      if (rs.wready === 1'b1) ax.wvalid <= 1'b0;
    end
    while (rs.bvalid !== 1'b1 && n < 100);
    ax.bready <= 1'b0;
    rr = rs.bresp;
    if (n >= 100) fails++;
    @(posedge clk);
  endtask : wr

  // Bus read into rd and rr
  task automatic rdr(input logic [5:0] a);
    int n;
    ax.araddr <= a;
    ax.arvalid <= 1'b1;
    ax.rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (rs.arready === 1'b1) ax.arvalid <= 1'b0;
    end
    while (rs.rvalid !== 1'b1 && n < 100);
    ax.rready <= 1'b0;
    rd = rs.rdata;
    rr = rs.rresp;
    if (n >= 100) fails++;
    @(posedge clk);
  endtask : rdr

  // Bit clock over 200 cycles: rising edges and spacing of the first two
  task automatic bper(output int p, output int nr);
    logic pv;
    int t, n;
    pv = pins.bclk;
    t = -1;
    p = 0;
    nr = 0;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (pins.bclk === 1'b1 && pv === 1'b0)
      begin
        if (t >= 0 && p == 0) p = n - t;
        t = n;
        nr++;
      end
      pv = pins.bclk;
    end
  endtask : bper

  task automatic s_regs;
    int i;
    for (i = 0; i < 9; i++)
    begin
      rdr(6'(i * 4));
      `CHK(rd, 32'(REG_RST))
    end
    rdr(6'h24);
    `CHK(rr, RESP_SLVERR)
    wr(6'h3c, 32'h1);
    `CHK(rr, RESP_SLVERR)
    wr(OFS_XFER_CTRL, 32'h02);  // Setting the end flag by software has no effect
    rdr(OFS_XFER_CTRL);
    `CHK(rd, 32'h0)
  endtask : s_regs

  task automatic s_rate;
    int p, nr, i;
    int exp_p[5] = '{2, 4, 8, 8, 4};
    logic [1:0] rate_v[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    wr(OFS_SUSPEND, 32'h60);
    wr(OFS_PIN_DIR, 32'h03);  // Clock and data only, no channel clock
    for (i = 0; i < 5; i++)
    begin
      wr(OFS_XFER_CTRL, 32'h0);
      wr(OFS_RATE, 32'(rate_v[i]));
      wr(OFS_FMT_PAR, (i == 4) ? 32'h20 : 32'h0);
      wr(OFS_XFER_CTRL, 32'h40);
      bper(p, nr);
      `CHK(p, exp_p[i])
    end
    `CHK({pins.bclk_oe, pins.sdat_oe}, 2'b11)
    `CHK(pins.lr_clock_oe, 1'b0)
    wr(OFS_FMT_PAR, 32'h0);
    wr(OFS_XFER_CTRL, 32'h0);
    wr(OFS_SUSPEND, 32'h20);  // Master enable without the system clock source
    wr(OFS_XFER_CTRL, 32'h40);
    bper(p, nr);
    `CHK(nr, 0)
    wr(OFS_XFER_CTRL, 32'h0);
    wr(OFS_SUSPEND, 32'h60);
  endtask : s_rate

  // One word; rj right-justifies, par turns on parity and the format check (16-bit only)
  task automatic s_xfer(input logic w24, input logic swp, input logic msb, input logic rj, input logic par,
    input logic [23:0] b);
    logic [23:0] w, e;
    int n, i, wd, st;
    wd = w24 ? 24 : 16;
    st = rj ? (int'(HALF_48FS) - wd - int'(par)) : 0;
    i_rx.words.delete();
    wr(OFS_PIN_DIR, 32'h07);
    wr(OFS_WORD_MODE, {24'h0, w24, w24, rj, 5'h0});
    wr(OFS_RATE, {27'h0, swp, 4'h0});
    wr(OFS_FMT_PAR, {27'h0, par, par, 3'h0});
    wr(OFS_XFER_COUNT, w24 ? 32'h3 : 32'h2);
    if (w24)
      bq = '{b[7:0], b[15:8], b[23:16]};
    else
      bq = '{b[7:0], b[15:8]};
    bdat <= b[7:0];
    bval <= 1'b1;
    wr(OFS_XFER_CTRL, {25'h0, 4'he, msb, 2'h1});
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(irq, 1'b1)
    rdr(OFS_XFER_CTRL);
    `CHK(rd[5], 1'b0)
    `CHK(rd[1], 1'b1)
    `CHK(bq.size(), 0)
    rdr(OFS_STATUS);
    `CHK(rd[1:0], {1'b1, par})
    if (par) wr(OFS_STATUS, 32'h1);
    w = w24 ? (swp ? {b[7:0], b[15:8], b[23:16]} : b) : {8'h0, swp ? {b[7:0], b[15:8]} : b[15:0]};
    e = '0;
    for (i = 0; i < wd; i++) e[st + i] = msb ? w[wd - 1 - i] : w[i];
    if (par) e[st + wd] = ^b[15:0];
    repeat (150) @(posedge clk);  // One channel pair of 96 cycles plus a half to close it
    `CHK(i_rx.words.size(), 1)
    if (i_rx.words.size() > 0) `CHK(i_rx.words[0], e)
    rdr(OFS_STATUS);
    `CHK(rd, 32'h0)
    wr(OFS_XFER_CTRL, 32'h0);
  endtask : s_xfer

  task automatic s_sus;
    int p, nr, i;
    for (i = 0; i < 4; i++)
    begin
      hsel <= 2'(i);
      pol <= i[0];
      hold <= 1'b1;
      wr(OFS_SUSPEND, 32'h68 | (i[0] << 2) | i);
      wr(OFS_XFER_CTRL, 32'h40);
      repeat (150) @(posedge clk);
      bper(p, nr);
      `CHK(nr, 0)
      hold <= 1'b0;
      bper(p, nr);
      `CHK(nr > 0, 1'b1)
      wr(OFS_XFER_CTRL, 32'h0);
    end
  endtask : s_sus

  task automatic give_verdict;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Watchdog: the whole run needs well under this span
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    give_verdict();
  end

  initial
  begin
    ax = '0;
    bdat = 8'h00;
    bval = 1'b0;
    hold = 1'b0;
    hsel = 2'h0;
    pol = 1'b0;
    fails = 0;
    tests_run = 0;
    srst = 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    s_regs();
    s_rate();
    s_xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 24'h00a5c3);
    s_xfer(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 24'h003c81);
    s_xfer(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 24'h96e1f4);
    s_xfer(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 24'h5a0f72);
    s_sus();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
